// >>> logic/ir_tx_pkg.sv
// Constants and types of the infrared transmit timer
// Operation
// RULE1: Timer holds a 9-bit down counter, an output-enable flag and a zero detector.
// RULE2: Loading a nonzero count starts the countdown.
// RULE3: Count drops once per 64 clocks, or per 128 with half rate selected.
// RULE4: At zero the detector raises timer end and counting stops.
// RULE5: Timer end stays high while the count is zero and the timer stopped.
// RULE6: Timer end releases the timer-wait halt; execution resumes after it.
// RULE7: Interval is loaded count plus one, times the tick period.
// RULE8: With output enabled, indicator low and IR high while running, reversed stopped.
// RULE9: Running with output enabled, IR carries the carrier when carrier enabled.
// RULE10: Carrier disable bit zero enables the carrier; one gives steady high.
// RULE11: Timer stop during carrier high waits for the carrier fall.
// RULE12: First carrier high pulse after start may be shortened.
// RULE13: Burst end may lead by one low width or lag by one high width.
// RULE14: Software may pulse IR by loading zero with or without output enable. Here a zero load leaves run and the burst gate low, so IR gives no pulse.
// RULE15: Timer keeps running, outputs included, in the clock-running halt.
// RULE16: In oscillator-stopped standby the timer stops and its count clears.
// RULE17: Standby is entered only with the status flag at zero.
// RULE18: Leaving any standby sets the status flag.
// RULE19: Wake already present at request: no standby, status flag set.
// RULE20: Carrier select gives fx/8, fx/64, fx/96 half duty, fx/96 third duty.
// RULE21: Indicator drives status only in output mode; pull-down then off.
// RULE22: A timer load writes enable flag and nine count bits at once.
package ir_tx_pkg;

    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_TIMER  = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_CMD    = 4'hc;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Tick periods in clock cycles, clk standing for the oscillator fx
    localparam int         TICK_SHORT    = 64;
    localparam int         TICK_LONG     = 128;
    localparam logic [6:0] TICK_SHORT_M1 = 7'(TICK_SHORT - 1);
    localparam logic [6:0] TICK_LONG_M1  = 7'(TICK_LONG - 1);

    // Carrier periods and high widths in clock cycles at full rate
    localparam logic [7:0] CAR_PER_8     = 8'h08;
    localparam logic [7:0] CAR_PER_64    = 8'h40;
    localparam logic [7:0] CAR_PER_96    = 8'h60;
    localparam logic [7:0] CAR_HI_THIRD  = 8'h20;

    localparam logic [2:0] HALT_TIMER_OP = 3'h5;

    typedef struct packed {
        logic       led_mode;
        logic       half_rate_select;
        logic       carrier_disable;
        logic [1:0] car_sel;
    } ctrl_type;

    localparam ctrl_type CTRL_RESET = 5'h13;

    typedef struct packed {
        logic       timer_out_enable;
        logic [8:0] count;
    } timer_word_type;

    typedef struct packed {
        logic       run;
        logic       stopped;
        logic       halted;
        logic       flag;
        logic       timer_end;
    } status_type;

    typedef struct packed {
        logic       clear_flag;
        logic       halt;
        logic [3:0] op;
    } cmd_type;

    typedef enum logic [1:0] {
        MODE_RUN  = 2'b00,
        MODE_HALT = 2'b01,
        MODE_STOP = 2'b10
    } mode_type;

    typedef struct packed {
        logic        awvalid;
        logic [3:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [3:0]  araddr;
        logic        rready;
    } axil_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_type;

endpackage

// >>> logic/carrier_gen.sv
// Carrier divider for the infrared output
`timescale 1ns/10ps
module carrier_gen
    import ir_tx_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       osc_run,
    input  wire logic [1:0] car_sel,
    input  wire logic       half_rate_select,
    output logic            carrier
);

    typedef struct packed {
        logic [7:0] cnt;
        logic       level;
    } car_state_type;

    car_state_type q;
    car_state_type d;
    logic [7:0]    per;
    logic [7:0]    hi;

    // Free running, so the first pulse of a burst may be short
    always_comb begin  // [RULE12]
        d = q;
        case (car_sel)  // [RULE20]
            2'b00: begin
                per = CAR_PER_8;
                hi  = CAR_PER_8 >> 1;
            end
            2'b01: begin
                per = CAR_PER_64;
                hi  = CAR_PER_64 >> 1;
            end
            2'b10: begin
                per = CAR_PER_96;
                hi  = CAR_PER_96 >> 1;
            end
            default: begin
                per = CAR_PER_96;
                hi  = CAR_HI_THIRD;
            end
        endcase
        if (half_rate_select) begin  // [RULE20]
            per = per << 1;
            hi  = hi << 1;
        end
        if (!osc_run) begin
            d.cnt   = 8'h00;
            d.level = 1'b0;
        end else begin
            d.cnt   = (q.cnt >= per - 8'h01) ? 8'h00 : q.cnt + 8'h01;
            d.level = d.cnt < hi;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign carrier = q.level;

endmodule

// >>> logic/ir_remote_tx_timer.sv
// Infrared transmit timer with standby control and an AXI4-Lite register slave
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module ir_remote_tx_timer
    import ir_tx_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    input  axil_req_type axi_req,
    output axil_rsp_type axi_rsp,
    input  wire logic   key_wake,
    output logic        ir_drive_out,
    output logic        tx_indicator_pin,
    output logic        tx_indicator_oe_n,
    output logic        indicator_pulldown_en,
    output logic        timer_end,
    output logic        cpu_halted,
    output logic        osc_stopped,
    output logic        resume_pulse
);

    typedef struct packed {
        logic        aw_got;
        logic [3:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        ctrl_type    ctrl;
        logic [8:0]  count;
        logic        timer_out_enable;
        logic        run;
        logic [6:0]  presc;
        logic        gate;
        logic        ir;
        logic        led;
        logic        flag;
        mode_type    mode;
        logic        resume;
    } state_type;

    state_type      q;
    state_type      d;
    logic           carrier;
    logic           tick;
    logic           tend;
    logic           aw_hs;
    logic           w_hs;
    logic           ar_hs;
    logic           twr;
    logic           wake_met;
    timer_word_type tw;
    cmd_type        cmd;
    status_type     st;

    carrier_gen u_carrier (
        .clk              (clk),
        .rst              (rst),
        .osc_run          (q.mode != MODE_STOP),
        .car_sel          (q.ctrl.car_sel),
        .half_rate_select (q.ctrl.half_rate_select),
        .carrier          (carrier)
    );

    // Zero detector: stopped with a zero count
    assign tend = !q.run && (q.count == 9'h000);  // [RULE1] [RULE5]

    always_comb begin
        d        = q;
        d.resume = 1'b0;
        twr      = 1'b0;
        tw       = timer_word_type'(q.w_data[9:0]);
        cmd      = cmd_type'(q.w_data[5:0]);
        wake_met = 1'b0;
        st       = '0;
        aw_hs    = axi_req.awvalid && !q.aw_got && !q.bvalid;
        w_hs     = axi_req.wvalid && !q.w_got && !q.bvalid;
        ar_hs    = axi_req.arvalid && !q.rvalid;

        // Write channel: address and data in either order, answer after both
        if (aw_hs) begin
            d.aw_got  = 1'b1;
            d.aw_addr = axi_req.awaddr;
        end
        if (w_hs) begin
            d.w_got  = 1'b1;
            d.w_data = axi_req.wdata;
            d.w_strb = axi_req.wstrb;
        end
        if (q.bvalid && axi_req.bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = RESP_OKAY;
            case (q.aw_addr)
                ADDR_CTRL: begin
                    if (q.w_strb[0]) begin
                        d.ctrl = ctrl_type'(q.w_data[4:0]);
                    end
                end
                ADDR_TIMER: begin
                    // Partial writes are dropped so the ten bits never tear
                    twr = &q.w_strb[1:0];  // [RULE22]
                end
                ADDR_STATUS: begin
                    d.bresp = RESP_OKAY;
                end
                ADDR_CMD: begin
                    if (q.w_strb[0]) begin
                        d.flag = q.flag && !cmd.clear_flag;
                    end
                end
                default: begin
                    d.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Read channel
        if (q.rvalid && axi_req.rready) begin
            d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            st.run       = q.run;
            st.stopped   = q.mode == MODE_STOP;
            st.halted    = q.mode == MODE_HALT;
            st.flag      = q.flag;
            st.timer_end = tend;
            case (axi_req.araddr)
                ADDR_CTRL: d.rdata = {27'h0, q.ctrl};
                ADDR_TIMER: d.rdata = {22'h0, q.timer_out_enable, q.count};
                ADDR_STATUS: d.rdata = {27'h0, st};
                ADDR_CMD: d.rdata = 32'h0;
                default: begin
                    d.rdata = 32'h0;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end

        // Tick prescaler
        tick = q.presc == (q.ctrl.half_rate_select ? TICK_LONG_M1 : TICK_SHORT_M1);  // [RULE3]
        d.presc = tick ? 7'h00 : q.presc + 7'h01;

        // Down counter; the final zero lasts one more tick before the stop
        if (tick && q.run) begin  // [RULE3] [RULE15]
            if (q.count == 9'h000) begin
                d.run = 1'b0;  // [RULE4] [RULE7]
            end else begin
                d.count = q.count - 9'h001;
            end
        end
        if (twr) begin
            d.count            = tw.count;  // [RULE22]
            d.timer_out_enable = tw.timer_out_enable;
            d.run              = tw.count != 9'h000;  // [RULE2]
            d.presc            = 7'h00;
        end

        // Standby: a halt command from the core
        if (q.aw_got && q.w_got && q.aw_addr == ADDR_CMD && q.w_strb[0] && cmd.halt
                && q.mode == MODE_RUN) begin
            wake_met = (cmd.op[2:0] == HALT_TIMER_OP) ? tend : key_wake;
            if (q.flag && !cmd.clear_flag) begin
                d.flag = wake_met;  // [RULE17]
            end else if (wake_met) begin
                d.flag = 1'b1;  // [RULE19]
            end else begin
                d.mode = (cmd.op[2:0] == HALT_TIMER_OP) ? MODE_HALT : MODE_STOP;  // [RULE17]
            end
        end
        case (q.mode)
            MODE_HALT: begin
                if (tend) begin
                    d.mode   = MODE_RUN;  // [RULE6]
                    d.flag   = 1'b1;  // [RULE18]
                    d.resume = 1'b1;
                end
            end
            MODE_STOP: begin
                // Oscillator stopped: no timer activity at all
                d.count            = 9'h000;  // [RULE16]
                d.timer_out_enable = 1'b0;
                d.run              = 1'b0;
                d.presc            = 7'h00;
                d.gate             = 1'b0;
                if (key_wake) begin
                    d.mode   = MODE_RUN;
                    d.flag   = 1'b1;  // [RULE18]
                    d.resume = 1'b1;
                end
            end
            MODE_RUN: begin
                d.mode = d.mode;
            end
            default: begin
                d.mode = MODE_RUN;
            end
        endcase

        // Burst gate waits for the carrier low so the last pulse stays whole
        if (q.mode != MODE_STOP) begin
            d.gate = (d.run && d.timer_out_enable)  // [RULE8]
                || (q.gate && carrier && !q.ctrl.carrier_disable);  // [RULE11] [RULE13]
        end
        d.ir  = d.gate && (d.ctrl.carrier_disable || carrier);  // [RULE9] [RULE10]
        d.led = !(d.run && d.timer_out_enable);  // [RULE8]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q      <= '0;
            q.ctrl <= CTRL_RESET;
            q.led  <= 1'b1;
            q.mode <= MODE_RUN;
        end else begin
            q <= d;
        end
    end

    assign axi_rsp.awready       = !q.aw_got && !q.bvalid;
    assign axi_rsp.wready        = !q.w_got && !q.bvalid;
    assign axi_rsp.bvalid        = q.bvalid;
    assign axi_rsp.bresp         = q.bresp;
    assign axi_rsp.arready       = !q.rvalid;
    assign axi_rsp.rvalid        = q.rvalid;
    assign axi_rsp.rdata         = q.rdata;
    assign axi_rsp.rresp         = q.rresp;
    assign ir_drive_out          = q.ir;
    assign tx_indicator_pin      = q.led;
    assign tx_indicator_oe_n     = !q.ctrl.led_mode;  // [RULE21]
    assign indicator_pulldown_en = !q.ctrl.led_mode;  // [RULE21]
    assign timer_end             = tend;
    assign cpu_halted            = q.mode != MODE_RUN;
    assign osc_stopped           = q.mode == MODE_STOP;
    assign resume_pulse          = q.resume;

    AST_LOAD_START: assert property (@(posedge clk) disable iff (rst)  // [RULE2]
        twr && tw.count != 9'h000 && q.mode != MODE_STOP |=> q.run && q.count == $past(tw.count))
        else $error("Nonzero load did not start the timer");

    AST_DECREMENT: assert property (@(posedge clk) disable iff (rst)  // [RULE3]
        tick && q.run && q.count != 9'h000 && !twr && q.mode != MODE_STOP
        |=> q.count == $past(q.count) - 9'h001)
        else $error("Counter did not step down on a tick");

    AST_END_HOLD: assert property (@(posedge clk) disable iff (rst)  // [RULE5]
        tend && !twr |=> tend)
        else $error("Timer end dropped without a load");

    AST_LAST_TICK: assert property (@(posedge clk) disable iff (rst)  // [RULE7]
        tick && q.run && q.count == 9'h001 && !twr && q.mode == MODE_RUN
        |=> q.run && !tend)
        else $error("Timer stopped before the extra zero tick");

    AST_LED_STATUS: assert property (@(posedge clk) disable iff (rst)  // [RULE8]
        q.led == !(q.run && q.timer_out_enable))
        else $error("Indicator does not follow the timer state");

    AST_STEADY_HIGH: assert property (@(posedge clk) disable iff (rst)  // [RULE10]
        q.gate && q.ctrl.carrier_disable |-> q.ir)
        else $error("Carrier disabled but output not steady high");

    AST_CARRIER_SYNC: assert property (@(posedge clk) disable iff (rst)  // [RULE11]
        q.gate && carrier && !q.ctrl.carrier_disable && q.mode != MODE_STOP |=> q.gate)
        else $error("Burst cut while carrier high");

    AST_HALT_WAKE: assert property (@(posedge clk) disable iff (rst)  // [RULE6]
        q.mode == MODE_HALT && tend |=> q.mode == MODE_RUN && q.flag && q.resume)
        else $error("Timer end did not release the halt");

    AST_STOP_CLEAR: assert property (@(posedge clk) disable iff (rst)  // [RULE16]
        q.mode == MODE_STOP |=> q.count == 9'h000 && !q.run && !q.ir)
        else $error("Timer active in oscillator stop");

    AST_FLAG_BLOCKS: assert property (@(posedge clk) disable iff (rst)  // [RULE17]
        q.mode == MODE_RUN && q.flag && !cmd.clear_flag
        |=> q.mode == MODE_RUN)
        else $error("Standby entered with the flag set");

    AST_NO_SELF_START: assert property (@(posedge clk) disable iff (rst)  // [RULE2]
        !q.run && !twr
        |=> !q.run)
        else $error("Timer started without a load");

    AST_ZERO_STOP: assert property (@(posedge clk) disable iff (rst)  // [RULE4]
        tick && q.run && q.count == 9'h000 && !twr
        |=> !q.run && tend)
        else $error("Zero count did not stop the timer");

    // Burst output: the gate follows the timer, the pin follows the gate
    AST_GATE_RUN: assert property (@(posedge clk) disable iff (rst)  // [RULE8]
        q.run && q.timer_out_enable
        |-> q.gate)
        else $error("Burst gate closed while the timer runs");

    AST_IR_QUIET: assert property (@(posedge clk) disable iff (rst)  // [RULE8]
        !q.gate
        |-> !q.ir)
        else $error("IR output high outside a burst");

    // The pin is registered, so it trails the carrier by one cycle
    AST_CARRIER_PASS: assert property (@(posedge clk) disable iff (rst)  // [RULE9]
        q.gate && !q.ctrl.carrier_disable
        |-> q.ir == $past(carrier))
        else $error("IR output does not follow the carrier");

    AST_FULL_LOAD: assert property (@(posedge clk) disable iff (rst)  // [RULE22]
        twr && q.mode != MODE_STOP
        |=> {q.timer_out_enable, q.count} == $past(tw))
        else $error("Timer load did not write all ten bits");

    // Standby: a met wake condition blocks entry, a key leaves the stop
    AST_WAKE_BLOCKS: assert property (@(posedge clk) disable iff (rst)  // [RULE19]
        wake_met
        |=> q.mode == MODE_RUN && q.flag)
        else $error("Standby entered although wake was met");

    AST_STOP_WAKE: assert property (@(posedge clk) disable iff (rst)  // [RULE18]
        q.mode == MODE_STOP && key_wake
        |=> q.mode == MODE_RUN && q.flag && q.resume)
        else $error("Key wake did not leave the stop");

    // Bus answers stand until taken; the master may hold off its ready
    AST_BVALID_HOLD: assert property (@(posedge clk) disable iff (rst)
        q.bvalid && !axi_req.bready
        |=> q.bvalid && $stable(q.bresp))
        else $error("Write response dropped before it was taken");

    AST_RVALID_HOLD: assert property (@(posedge clk) disable iff (rst)
        q.rvalid && !axi_req.rready
        |=> q.rvalid && $stable(q.rdata))
        else $error("Read data dropped before it was taken");

endmodule

// >>> verif/ir_led_model.sv
// Behavioural model of the infrared LED driver and the transmit indicator LED
`timescale 1ns/10ps
module ir_led_model (
    input  wire logic   clk,
    input  wire logic   ir_drive_out,
    input  wire logic   tx_indicator_pin,
    input  wire logic   tx_indicator_oe_n,
    input  wire logic   indicator_pulldown_en,
    output logic [31:0] ir_high_cycles,
    output logic [31:0] ir_rises,
    output logic [31:0] lit_cycles
);
    logic ir_last;
    logic lvl_last;
    logic wire_lvl;

    // A floating line without pull-down shows the inverse of its last level
    assign wire_lvl = !tx_indicator_oe_n ? tx_indicator_pin :
                      indicator_pulldown_en ? 1'b0 : !lvl_last;

    initial begin
        ir_last = 1'b0;
        lvl_last = 1'b1;
        ir_high_cycles = '0;
        ir_rises = '0;
        lit_cycles = '0;
    end

    always @(posedge clk) begin
        ir_last <= ir_drive_out;
        lvl_last <= wire_lvl;
        if (ir_drive_out === 1'b1) begin
            ir_high_cycles <= ir_high_cycles + 32'h1;
        end
        if (ir_drive_out === 1'b1 && ir_last !== 1'b1) begin
            ir_rises <= ir_rises + 32'h1;
        end
        // The indicator LED sinks into the pin, so a low level lights it
        if (wire_lvl === 1'b0) begin
            lit_cycles <= lit_cycles + 32'h1;
        end
    end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the infrared transmit timer
`timescale 1ns/10ps
module tb_top;
    import ir_tx_pkg::*;

    logic         clk;
    logic         rst;
    axil_req_type req;
    axil_rsp_type rsp;
    logic         key_wake;
    logic         ir_drive_out;
    logic         tx_indicator_pin;
    logic         tx_indicator_oe_n;
    logic         indicator_pulldown_en;
    logic         timer_end;
    logic         cpu_halted;
    logic         osc_stopped;
    logic         resume_pulse;
    logic [31:0]  ir_high, ir_rises, lit, b_run, b_hi, b_ri, b_lit, rd;
    logic [31:0]  run_cyc = '0;
    logic [1:0]   rs;
    int           miscompares, n_compared, i, dur;
    // Each row: control word, count, tick, carrier period, carrier high width
    int t_ctrl [7] = '{'h14, 'h1c, 'h10, 'h11, 'h12, 'h13, 'h18};
    int t_n    [7] = '{2, 1, 11, 11, 11, 11, 5};
    int t_tick [7] = '{64, 128, 64, 64, 64, 64, 128};
    int t_per  [7] = '{0, 0, 8, 64, 96, 96, 16};
    int t_hi   [7] = '{0, 0, 4, 32, 48, 32, 8};

    ir_remote_tx_timer uut (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
        .key_wake(key_wake), .ir_drive_out(ir_drive_out), .tx_indicator_pin(tx_indicator_pin),
        .tx_indicator_oe_n(tx_indicator_oe_n), .indicator_pulldown_en(indicator_pulldown_en),
        .timer_end(timer_end), .cpu_halted(cpu_halted), .osc_stopped(osc_stopped),
        .resume_pulse(resume_pulse));

    ir_led_model led (.clk(clk), .ir_drive_out(ir_drive_out),
        .tx_indicator_pin(tx_indicator_pin), .tx_indicator_oe_n(tx_indicator_oe_n),
        .indicator_pulldown_en(indicator_pulldown_en), .ir_high_cycles(ir_high),
        .ir_rises(ir_rises), .lit_cycles(lit));

    always #5 clk = ~clk;

    // Counts the cycles for which the timer is running
    always @(posedge clk) begin
        if (timer_end === 1'b0) begin
            run_cyc <= run_cyc + 32'h1;
        end
    end

    task automatic rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
        n_compared++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, lo);
        end
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        rng(g, e, e);
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        bit awd, wd, done;
        int n;
        awd = 0;
        wd = 0;
        done = 0;
        n = 0;
        r = 2'h3;
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awd && wd && rsp.bvalid === 1'b1) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                done = 1;
            end
            if (!awd && rsp.awready === 1'b1) begin
                awd = 1;
                req.awvalid <= 1'b0;
            end
            if (!wd && rsp.wready === 1'b1) begin
                wd = 1;
                req.wvalid <= 1'b0;
            end
        end while (!done && n < 100);
        chk(32'(done), 32'h1);
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ard, done;
        int n;
        ard = 0;
        done = 0;
        n = 0;
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (ard && rsp.rvalid === 1'b1) begin
                d = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'b0;
                done = 1;
            end
            if (!ard && rsp.arready === 1'b1) begin
                ard = 1;
                req.arvalid <= 1'b0;
            end
        end while (!done && n < 100);
        chk(32'(done), 32'h1);
    endtask

    // Waits for the resume pulse (pulse set) or for the timer-end level
    task automatic wait_for(input bit pulse, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((pulse ? resume_pulse : timer_end) !== 1'b1 && n < lim);
        rng(32'(n), 32'h1, 32'(lim - 1));
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #400000;
        miscompares++;
        give_verdict();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        key_wake = 1'b0;
        miscompares = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'(ir_drive_out), 32'h0);
        chk(32'(tx_indicator_pin), 32'h1);
        chk(32'(timer_end), 32'h1);
        chk(32'(indicator_pulldown_en), 32'h0);
        axi_wr(4'h2, 32'h0, rs);
        chk(32'(rs), 32'(RESP_SLVERR));
        axi_rd(4'h2, rd, rs);
        chk(32'(rs), 32'(RESP_SLVERR));
        axi_wr(ADDR_STATUS, 32'h1f, rs);
        axi_rd(ADDR_STATUS, rd, rs);
        chk(rd, 32'h01);
        axi_rd(ADDR_CTRL, rd, rs);
        chk(rd, 32'h13);
        for (i = 0; i < 7; i++) begin
            axi_wr(ADDR_CTRL, 32'(t_ctrl[i]), rs);
            b_run = run_cyc;
            b_hi = ir_high;
            b_ri = ir_rises;
            b_lit = lit;
            axi_wr(ADDR_TIMER, 32'h200 | 32'(t_n[i]), rs);
            dur = (t_n[i] + 1) * t_tick[i];
            wait_for(0, 2000);
            repeat (200) @(posedge clk);
            chk(run_cyc - b_run, 32'(dur));
            chk(lit - b_lit, 32'(dur));
            chk(32'(ir_drive_out), 32'h0);
            if (t_per[i] == 0) begin
                chk(ir_high - b_hi, 32'(dur));
                chk(ir_rises - b_ri, 32'h1);
            end else begin
                rng(ir_rises - b_ri, 32'(dur / t_per[i] - 1), 32'(dur / t_per[i] + 1));
                rng(ir_high - b_hi, 32'(dur * t_hi[i] / t_per[i] - t_per[i]),
                    32'(dur * t_hi[i] / t_per[i] + t_per[i]));
            end
        end
        b_run = run_cyc;
        b_hi = ir_high;
        b_lit = lit;
        axi_wr(ADDR_TIMER, 32'h003, rs);
        wait_for(0, 1000);
        chk(run_cyc - b_run, 32'h200);
        chk(ir_high - b_hi, 32'h0);
        chk(lit - b_lit, 32'h0);
        axi_wr(ADDR_TIMER, 32'h200, rs);
        axi_rd(ADDR_STATUS, rd, rs);
        chk(rd, 32'h01);
        axi_wr(ADDR_CTRL, 32'h04, rs);
        chk(32'(tx_indicator_oe_n), 32'h1);
        chk(32'(indicator_pulldown_en), 32'h1);
        axi_wr(ADDR_CTRL, 32'h14, rs);
        axi_wr(ADDR_TIMER, 32'h201, rs);
        axi_wr(ADDR_CMD, 32'h35, rs);
        repeat (4) @(posedge clk);
        chk(32'(cpu_halted), 32'h1);
        chk(32'(ir_drive_out), 32'h1);
        chk(32'(tx_indicator_pin), 32'h0);
        wait_for(1, 300);
        repeat (2) @(posedge clk);
        chk(32'(cpu_halted), 32'h0);
        axi_rd(ADDR_STATUS, rd, rs);
        chk(rd, 32'h03);
        axi_wr(ADDR_TIMER, 32'h232, rs);
        axi_wr(ADDR_CMD, 32'h15, rs);
        repeat (4) @(posedge clk);
        chk(32'(cpu_halted), 32'h0);
        axi_rd(ADDR_STATUS, rd, rs);
        chk(rd, 32'h10);
        key_wake <= 1'b1;
        axi_wr(ADDR_CMD, 32'h10, rs);
        repeat (4) @(posedge clk);
        chk(32'(osc_stopped), 32'h0);
        axi_rd(ADDR_STATUS, rd, rs);
        chk(rd, 32'h12);
        key_wake <= 1'b0;
        axi_wr(ADDR_CMD, 32'h30, rs);
        repeat (4) @(posedge clk);
        chk(32'(osc_stopped), 32'h1);
        chk(32'(timer_end), 32'h1);
        chk(32'(ir_drive_out), 32'h0);
        key_wake <= 1'b1;
        wait_for(1, 50);
        repeat (2) @(posedge clk);
        chk(32'(osc_stopped), 32'h0);
        key_wake <= 1'b0;
        axi_rd(ADDR_STATUS, rd, rs);
        chk(rd, 32'h03);
        give_verdict();
    end
endmodule
